// ===== hdl/ssp_pkg.sv
package ssp_pkg;

   // ------------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int LOCK_WIN_NS = 15;
   localparam int LOCK_WIN_CYC = (LOCK_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCK_GOOD_CNT = 4;
   localparam int SYNC_STAGES = 2;

   // ------------------------------------------------------------------
   // Programming word layout
   // ------------------------------------------------------------------
   localparam int R_W = 14;
   localparam int A_W = 5;
   localparam int B_W = 11;
   localparam int LDSEL_W = 2;
   localparam int WORD_W = 18;
   localparam int CTRL_POS = 0;
   localparam int FIELD_LSB = 1;
   localparam logic CTRL_FB = 1'b1;

   // ------------------------------------------------------------------
   // Prescaler moduli
   // ------------------------------------------------------------------
   localparam logic [5:0] PRE_LOW = 6'h20;
   localparam logic [5:0] PRE_HIGH = 6'h21;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [R_W-1:0] R_RESET = 14'h0001;
   localparam logic [A_W-1:0] A_RESET = 5'h00;
   localparam logic [B_W-1:0] B_RESET = 11'h001;

   typedef enum logic [1:0] {
      SSP_LD_REF = 2'h0,
      SSP_LD_FB = 2'h1,
      SSP_LD_DIGITAL = 2'h2,
      SSP_LD_ANALOG = 2'h3
   } ssp_ldsel_t;

   typedef struct packed {
      ssp_ldsel_t ld_sel;
      logic [R_W-1:0] r_count;
   } ssp_ref_t;

   typedef struct packed {
      logic [B_W-1:0] b_count;
      logic [A_W-1:0] a_count;
   } ssp_fb_t;

   typedef struct packed {
      logic up;
      logic dn;
      logic oe;
   } ssp_cp_t;

   typedef struct packed {
      logic out;
      logic oe;
   } ssp_ld_t;

endpackage : ssp_pkg

// ===== hdl/ssp_synth_port.sv
`timescale 1ns/100ps

module ssp_synth_port (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic load_strobe,
   input wire logic chip_en,
   input wire logic osc_in,
   input wire logic rf_in,
   output ssp_pkg::ssp_cp_t charge_pump_out,
   output ssp_pkg::ssp_ld_t lock_detect_out
);
   import ssp_pkg::*;

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   localparam int NPIN = 5;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s;
   logic [NPIN-1:0] pin_d;

   assign pin_raw = {rf_in, osc_in, load_strobe, serial_data, serial_clk};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         logic [SYNC_STAGES-1:0] meta_reg;
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               meta_reg <= '0;
            end else if (clk_en) begin
               meta_reg <= {meta_reg[SYNC_STAGES-2:0], pin_raw[gi]};
            end
         end
         assign pin_s[gi] = meta_reg[SYNC_STAGES-1];
      end
   endgenerate

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pin_d <= '0;
      end else if (clk_en) begin
         pin_d <= pin_s;
      end
   end

   logic sclk_rise;
   logic sdata_s;
   logic load_rise;
   logic osc_rise;
   logic rf_rise;
   assign sclk_rise = pin_s[0] & ~pin_d[0];
   assign sdata_s = pin_s[1];
   assign load_rise = pin_s[2] & ~pin_d[2];
   assign osc_rise = pin_s[3] & ~pin_d[3];
   assign rf_rise = pin_s[4] & ~pin_d[4];

   // ------------------------------------------------------------------
   // Power-down reset
   // ------------------------------------------------------------------
   // Chip enable clears the core asynchronously; release is synchronised so
   // that the core never leaves power-down on a partial clock edge.
   logic pd_clr_b;
   logic [1:0] pd_sync_reg;
   logic core_rst_b;
   assign pd_clr_b = rst_b & chip_en;

   always_ff @(posedge mclk or negedge pd_clr_b) begin
      if (!pd_clr_b) begin
         pd_sync_reg <= 2'h0;
      end else if (clk_en) begin
         pd_sync_reg <= {pd_sync_reg[0], 1'b1};
      end
   end
   assign core_rst_b = pd_sync_reg[1] & pd_clr_b;

   // ------------------------------------------------------------------
   // Serial shift and load
   // ------------------------------------------------------------------
   // Programming state survives power-down, as only the system reset clears it.
   logic [WORD_W-1:0] shift_reg;
   ssp_ref_t ref_reg;
   ssp_fb_t fb_reg;
   logic ctrl_bit;
   assign ctrl_bit = shift_reg[CTRL_POS];

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         shift_reg <= '0;
      end else if (clk_en && sclk_rise) begin
         shift_reg <= {shift_reg[WORD_W-2:0], sdata_s};
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ref_reg <= '{ld_sel: SSP_LD_REF, r_count: R_RESET};
         fb_reg <= '{b_count: B_RESET, a_count: A_RESET};
      end else if (clk_en && load_rise) begin
         if (ctrl_bit == CTRL_FB) begin
            fb_reg <= ssp_fb_t'(shift_reg[FIELD_LSB +: A_W + B_W]);
         end else begin
            ref_reg <= ssp_ref_t'(shift_reg[FIELD_LSB +: R_W + LDSEL_W]);
         end
      end
   end

   // ------------------------------------------------------------------
   // Reference divider
   // ------------------------------------------------------------------
   logic [R_W-1:0] r_cnt_reg;
   logic ref_pulse_reg;

   always_ff @(posedge mclk or negedge core_rst_b) begin
      if (!core_rst_b) begin
         r_cnt_reg <= '0;
         ref_pulse_reg <= 1'b0;
      end else if (clk_en) begin
         ref_pulse_reg <= 1'b0;
         if (osc_rise) begin
            if (r_cnt_reg + R_W'(1) >= ref_reg.r_count) begin
               r_cnt_reg <= '0;
               ref_pulse_reg <= 1'b1;
            end else begin
               r_cnt_reg <= r_cnt_reg + R_W'(1);
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Dual-modulus prescaler and feedback divider
   // ------------------------------------------------------------------
   // Division is 32*B + A; the swallow count must not exceed B.
   logic [5:0] pre_cnt_reg;
   logic [5:0] pre_mod;
   logic [A_W-1:0] a_rem_reg;
   logic [B_W-1:0] b_rem_reg;
   logic fb_pulse_reg;
   assign pre_mod = (a_rem_reg != '0) ? PRE_HIGH : PRE_LOW;

   always_ff @(posedge mclk or negedge core_rst_b) begin
      if (!core_rst_b) begin
         pre_cnt_reg <= '0;
         a_rem_reg <= A_RESET;
         b_rem_reg <= B_RESET;
         fb_pulse_reg <= 1'b0;
      end else if (clk_en) begin
         fb_pulse_reg <= 1'b0;
         if (rf_rise) begin
            if (pre_cnt_reg + 6'h01 >= pre_mod) begin
               pre_cnt_reg <= '0;
               if (b_rem_reg <= B_W'(1)) begin
                  b_rem_reg <= fb_reg.b_count;
                  a_rem_reg <= fb_reg.a_count;
                  fb_pulse_reg <= 1'b1;
               end else begin
                  b_rem_reg <= b_rem_reg - B_W'(1);
                  if (a_rem_reg != '0) begin
                     a_rem_reg <= a_rem_reg - A_W'(1);
                  end
               end
            end else begin
               pre_cnt_reg <= pre_cnt_reg + 6'h01;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Phase detector, charge pump and lock detect
   // ------------------------------------------------------------------
   logic up_reg;
   logic dn_reg;
   logic [7:0] err_cnt_reg;
   logic [3:0] good_cnt_reg;
   logic locked;
   assign locked = (good_cnt_reg == 4'(LOCK_GOOD_CNT));

   always_ff @(posedge mclk or negedge core_rst_b) begin
      if (!core_rst_b) begin
         up_reg <= 1'b0;
         dn_reg <= 1'b0;
      end else if (clk_en) begin
         if ((up_reg | ref_pulse_reg) && (dn_reg | fb_pulse_reg)) begin
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
         end else begin
            up_reg <= up_reg | ref_pulse_reg;
            dn_reg <= dn_reg | fb_pulse_reg;
         end
      end
   end

   always_ff @(posedge mclk or negedge core_rst_b) begin
      if (!core_rst_b) begin
         err_cnt_reg <= '0;
         good_cnt_reg <= '0;
      end else if (clk_en) begin
         if (up_reg ^ dn_reg) begin
            if (err_cnt_reg != 8'hff) begin
               err_cnt_reg <= err_cnt_reg + 8'h01;
            end
         end else if (err_cnt_reg != '0) begin
            err_cnt_reg <= '0;
            if (err_cnt_reg > 8'(LOCK_WIN_CYC)) begin
               good_cnt_reg <= '0;
            end else if (!locked) begin
               good_cnt_reg <= good_cnt_reg + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge core_rst_b) begin
      if (!core_rst_b) begin
         charge_pump_out <= '{up: 1'b0, dn: 1'b0, oe: 1'b0};
      end else if (clk_en) begin
         charge_pump_out <= '{up: up_reg, dn: dn_reg, oe: 1'b1};
      end
   end

   always_ff @(posedge mclk or negedge core_rst_b) begin
      if (!core_rst_b) begin
         lock_detect_out <= '{out: 1'b0, oe: 1'b1};
      end else if (clk_en) begin
         unique case (ref_reg.ld_sel)
            SSP_LD_REF: lock_detect_out <= '{out: ref_pulse_reg, oe: 1'b1};
            SSP_LD_FB: lock_detect_out <= '{out: fb_pulse_reg, oe: 1'b1};
            SSP_LD_DIGITAL: lock_detect_out <= '{out: locked, oe: 1'b1};
            SSP_LD_ANALOG: lock_detect_out <= '{out: 1'b0, oe: up_reg ^ dn_reg};
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   sequence s_load_fb;
      clk_en && load_rise && ctrl_bit;
   endsequence

   sequence s_load_ref;
      clk_en && load_rise && !ctrl_bit;
   endsequence

   a_shift_on_edge: assert property (@(posedge mclk) disable iff (!rst_b)
      clk_en && sclk_rise |=> shift_reg == {$past(shift_reg[WORD_W-2:0]), $past(sdata_s)})
      else $error("Shift register did not advance on serial clock edge.");

   a_load_fb_word: assert property (@(posedge mclk) disable iff (!rst_b)
      s_load_fb |=> fb_reg == $past(shift_reg[FIELD_LSB +: A_W + B_W]))
      else $error("Feedback register not loaded on strobe.");

   a_load_ref_word: assert property (@(posedge mclk) disable iff (!rst_b)
      s_load_ref |=> ref_reg == $past(shift_reg[FIELD_LSB +: R_W + LDSEL_W]) && $stable(fb_reg))
      else $error("Reference register not loaded or feedback disturbed.");

   a_pd_cp_float: assert property (@(posedge mclk) disable iff (!rst_b)
      !chip_en |-> !charge_pump_out.oe ##1 !charge_pump_out.oe [*1])
      else $error("Charge pump driven while powered down.");

   a_pd_core_held: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(chip_en) |-> !charge_pump_out.oe && !ref_pulse_reg && !fb_pulse_reg)
      else $error("Core active at power-down release.");

   a_ld_ref_src: assert property (@(posedge mclk) disable iff (!core_rst_b)
      clk_en && ref_reg.ld_sel == SSP_LD_REF && ref_pulse_reg
      |=> lock_detect_out.out && lock_detect_out.oe)
      else $error("Lock detect does not follow reference divider.");

   a_ld_open_drain: assert property (@(posedge mclk) disable iff (!core_rst_b)
      clk_en && ref_reg.ld_sel == SSP_LD_ANALOG |=> !lock_detect_out.out)
      else $error("Analog lock detect drove a high level.");

   a_ld_cmos_drive: assert property (@(posedge mclk) disable iff (!core_rst_b)
      clk_en && ref_reg.ld_sel == SSP_LD_DIGITAL |=> lock_detect_out.oe
      && lock_detect_out.out == $past(locked))
      else $error("Digital lock detect not actively driven.");

   a_pre_modulus: assert property (@(posedge mclk) disable iff (!core_rst_b)
      pre_cnt_reg < pre_mod && (a_rem_reg != '0 || pre_cnt_reg < PRE_LOW))
      else $error("Prescaler count outside 32/33 range.");

endmodule : ssp_synth_port

// ===== tb/ssp_host_model.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Host side of the three-wire programming link
// ------------------------------------------------------------------
module ssp_host_model (
   output logic serial_clk,
   output logic serial_data,
   output logic load_strobe
);
   // The shift clock stands still low between words, as a host does.
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      load_strobe = 1'b0;
   end

   // Data changes mid-low phase, so it is steady 31 ns before and 94 ns after each rising edge.
   task automatic send_word(input logic [17:0] w);
      // Starting off the system clock edges keeps every pin change clear of the sampling flops.
      #2;
      for (int i = 17; i >= 0; i--) begin
         serial_data = w[i];
         #31;
         serial_clk = 1'b1;
         #62.5;
         serial_clk = 1'b0;
         #31.5;
      end
      #40;
      load_strobe = 1'b1;
      #125;
      load_strobe = 1'b0;
      // A released data line must not keep showing the last bit.
      serial_data = ~w[0];
   endtask : send_word
endmodule : ssp_host_model

// ===== tb/ssp_synth_port_tb_top.sv
`timescale 1ns/100ps

module ssp_synth_port_tb_top;
   import ssp_pkg::*;

   logic mclk;
   logic rst_b;
   logic clk_en;
   logic chip_en;
   logic osc_in;
   logic rf_in;
   wire serial_clk;
   wire serial_data;
   wire load_strobe;
   ssp_cp_t charge_pump_out;
   ssp_ld_t lock_detect_out;
   int err_count;
   int cmp_count;
   int pulse_cnt;
   int high_cnt;
   int oe_low_cnt;
   int frz_start;
   // Behavioural model: the divide ratios and lock-detect select of the last words sent.
   int m_r;
   int m_n;
   int m_sel;
   logic [17:0] sent_q[$];

   ssp_synth_port uut (
      .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .serial_clk(serial_clk),
      .serial_data(serial_data), .load_strobe(load_strobe), .chip_en(chip_en),
      .osc_in(osc_in), .rf_in(rf_in), .charge_pump_out(charge_pump_out),
      .lock_detect_out(lock_detect_out)
   );

   ssp_host_model host (
      .serial_clk(serial_clk), .serial_data(serial_data), .load_strobe(load_strobe)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ------------------------------------------------------------------
   // Output monitors
   // ------------------------------------------------------------------
   always @(posedge mclk) begin
      if (lock_detect_out.out === 1'b1 && lock_detect_out.oe === 1'b1) pulse_cnt++;
      if (lock_detect_out.out === 1'b1) high_cnt++;
      if (lock_detect_out.oe !== 1'b1) oe_low_cnt++;
   end

   task automatic report_and_stop();
      if (err_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t ns: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   // Toggles osc_in (bit 0) and/or rf_in (bit 1) for n rising edges, 3 mclk high, 3 low.
   task automatic toggle(input int n, input logic [1:0] mask);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk);
         if (mask[0]) osc_in <= 1'b1;
         if (mask[1]) rf_in <= 1'b1;
         repeat (3) @(posedge mclk);
         osc_in <= 1'b0;
         rf_in <= 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask : toggle

   // Aligns on one divider pulse, then counts pulses over k full periods of ratio div.
   task automatic count_periods(input int div, input int k, input logic [1:0] mask);
      int start;
      start = pulse_cnt;
      for (int i = 0; i < div + 2 && pulse_cnt == start; i++) toggle(1, mask);
      if (pulse_cnt == start) begin
         err_count++;
         report_and_stop();
      end
      repeat (10) @(posedge mclk);
      start = pulse_cnt;
      toggle(k * div, mask);
      repeat (10) @(posedge mclk);
      chk(pulse_cnt - start, k);
   endtask : count_periods

   task automatic load_ref(input int r, input int sel);
      logic [17:0] w;
      w = {1'b0, sel[1:0], r[13:0], 1'b0};
      sent_q.push_back(w);
      host.send_word(w);
      m_r = r;
      m_sel = sel;
      repeat (10) @(posedge mclk);
   endtask : load_ref

   task automatic load_fb(input int b, input int a);
      logic [17:0] w;
      w = {1'b0, b[10:0], a[4:0], 1'b1};
      sent_q.push_back(w);
      host.send_word(w);
      m_n = 32 * b + a;
      repeat (10) @(posedge mclk);
   endtask : load_fb

   initial begin
      err_count = 0;
      cmp_count = 0;
      pulse_cnt = 0;
      high_cnt = 0;
      oe_low_cnt = 0;
      rst_b = 1'b0;
      clk_en = 1'b1;
      chip_en = 1'b1;
      osc_in = 1'b0;
      rf_in = 1'b0;
      void'($urandom(32'hdfc41d89));
      repeat (5) @(posedge mclk);
      #1;
      chk(charge_pump_out, 3'h0);
      chk(lock_detect_out, 2'h1);
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (10) @(posedge mclk);
      #1;
      chk(charge_pump_out.oe, 1'b1);
      // Random reference ratio, reference output on the pin.
      load_ref(2 + ($urandom % 8), SSP_LD_REF);
      count_periods(m_r, 3, 2'h1);
      // Reference pulses alone leave the pump request up standing, with down idle.
      chk(charge_pump_out, 3'h5);
      // A low clock enable freezes the dividers, so oscillator edges are ignored.
      clk_en <= 1'b0;
      frz_start = pulse_cnt;
      toggle(2 * m_r, 2'h1);
      chk(pulse_cnt - frz_start, 0);
      clk_en <= 1'b1;
      // Back-to-back words: feedback N = 32*B+A, then feedback output selected.
      load_fb(1, 1);
      load_ref(m_r, SSP_LD_FB);
      count_periods(m_n, 2, 2'h2);
      // The first feedback pulse cancels the standing up request; later ones leave down set.
      chk(charge_pump_out, 3'h3);
      chk(sent_q.size(), 3);
      // Power down: no clock edge needed to float the pump.
      @(posedge mclk);
      chip_en <= 1'b0;
      #1;
      chk(charge_pump_out.oe, 1'b0);
      load_ref(4, SSP_LD_REF);
      start_low_check();
      chip_en <= 1'b1;
      repeat (10) @(posedge mclk);
      count_periods(m_r, 2, 2'h1);
      // Digital lock is always driven.
      load_ref(m_r, SSP_LD_DIGITAL);
      oe_low_cnt = 0;
      toggle(20, 2'h3);
      chk(oe_low_cnt, 0);
      // Analog lock only ever pulls low.
      load_ref(m_r, SSP_LD_ANALOG);
      high_cnt = 0;
      toggle(20, 2'h3);
      chk(high_cnt, 0);
      report_and_stop();
   end

   // While powered down no divider output may appear, even with the oscillator running.
   task automatic start_low_check();
      int start;
      start = pulse_cnt;
      toggle(12, 2'h1);
      chk(pulse_cnt - start, 0);
      chk(charge_pump_out.oe, 1'b0);
   endtask : start_low_check

   initial begin
      #800000;
      err_count++;
      report_and_stop();
   end
endmodule : ssp_synth_port_tb_top
